/* File: pcrc_top.sv */
// clock generator and reset control: reference merge, x5 multiplier
// with lock counter, divider, phase clocks and reset bus drain
// assumes all pins synchronous to pclk; registers reached over apb
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps

module pcrc_top
   import pcrc_pkg::*;
#(
   parameter int NUM_INT  = 4,
   parameter int LOST_CYC = `PCRC_REF_LOST_CYC
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic [11:0]        paddr,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   input  wire logic               crystal_input,
   input  wire logic               external_reference_input,
   input  wire logic               clock_mode_select_low,
   input  wire logic               clock_mode_select_high,
   input  wire logic               device_reset_n,
   input  wire logic [NUM_INT-1:0] external_interrupt_n,
   input  wire logic               output_float_request_n,
   input  wire logic               bus_access_pending,
   output logic                    crystal_drive_output,
   output logic                    multiplier_power_on,
   output logic                    phase_clock_one,
   output logic                    phase_clock_three,
   output logic                    clock_out_oe,
   output logic                    bus_pins_oe,
   output logic                    bus_access_end,
   output logic                    core_in_reset
);
   function automatic logic addr_is(input logic [11:0] a, input logic [11:0] ofs);
      addr_is = (a == ofs);
   endfunction : addr_is

   pcrc_ref_t  ref_info;
   pcrc_mode_t mode;
   pcrc_div_t  div_sel_ff;
   pcrc_bus_t  bus_st_ff;
   pcrc_bus_t  nxt_bus_st;
   logic       compat_ff;
   logic       rst_n_ff;
   logic       rst_prev_ff;
   logic       rst_fall;
   logic       wake;
   logic       wr_en;
   logic [11:0] acc_ff;
   logic [12:0] acc_sum;
   logic       x5_tick;
   logic       half_tog_ff;
   logic       half_tick;
   logic [7:0] lock_cnt_ff;
   logic       lock_done_ff;
   logic       x5_use_ff;
   logic       lock_adv;
   logic       mult_tick;
   logic       core_tick;
   logic       phase_one_ff;
   logic       phase_three_ff;
   logic       oe_clr_n;
   logic       clk_oe_ff;
   logic       bus_oe_ff;
   logic [3:0] drain_cnt_ff;
   logic       drain_done;
   logic       end_ff;
   logic       in_rst_ff;
   logic       crystal_drive_output_ff;
   logic       pwr_ff;
   logic [31:0] prdata_ff;
   logic       pready_ff;
   logic       pslverr_ff;
   logic [31:0] stat;

   pcrc_ref_front #(
      .LOST_CYC                 (LOST_CYC)
   ) u_ref (
      .pclk                     (pclk),
      .presetn                  (presetn),
      .crystal_input            (crystal_input),
      .external_reference_input (external_reference_input),
      .ref_info                 (ref_info)
   );

   // mode pins are static in operation, so no resync is needed
   assign mode = pcrc_mode_t'({clock_mode_select_low, clock_mode_select_high});

   // device reset pin, edge found on registered copies
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_n_ff    <= 1'b0;
         rst_prev_ff <= 1'b0;
      end else begin
         rst_n_ff    <= device_reset_n;
         rst_prev_ff <= rst_n_ff;
      end
   end

   assign rst_fall = rst_prev_ff & ~rst_n_ff;

   // five output periods per reference period by rate accumulation
   assign acc_sum = {1'b0, acc_ff} + 13'(`PCRC_MULT);
   assign x5_tick = ref_info.acquired && (acc_sum >= {1'b0, ref_info.period});

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         acc_ff <= 12'h000;
      else if (!ref_info.acquired)
         acc_ff <= 12'h000;
      else if (x5_tick)
         acc_ff <= 12'(acc_sum - {1'b0, ref_info.period});
      else
         acc_ff <= acc_sum[11:0];
   end

   // half-reference clock, used by the half mode and during lock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         half_tog_ff <= 1'b0;
      else if (ref_info.rise)
         half_tog_ff <= ~half_tog_ff;
   end

   assign half_tick = ref_info.rise & half_tog_ff;

   // lock counter frozen in reset or without reference
   assign lock_adv = (mode == PCRC_MODE_X5) && rst_n_ff && ref_info.rise
                     && ref_info.present && !lock_done_ff;

   // done is sticky, so later resets do not restart it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_cnt_ff  <= 8'h00;
         lock_done_ff <= 1'b0;
      end else if (lock_adv) begin
         lock_cnt_ff <= lock_cnt_ff + 8'h01;
         if (lock_cnt_ff == `PCRC_LOCK_LAST)
            lock_done_ff <= 1'b1;
      end
   end

   // x5 engaged only on a half-rate boundary, so no short pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         x5_use_ff <= 1'b0;
      else if (mode != PCRC_MODE_X5)
         x5_use_ff <= 1'b0;
      else if (lock_done_ff && half_tick)
         x5_use_ff <= 1'b1;
   end

   always_comb begin
      case (mode)
         PCRC_MODE_HALF: mult_tick = half_tick;
         PCRC_MODE_X5:   mult_tick = x5_use_ff ? x5_tick : half_tick;
         default:        mult_tick = ref_info.rise;
      endcase
   end

   // wake from clock stop on any low reset or interrupt pin
   assign wake  = (div_sel_ff == PCRC_DIV_STOP)
                  && (!rst_n_ff || (external_interrupt_n != {NUM_INT{1'b1}}));
   assign wr_en = psel && penable && pwrite && pready_ff
                  && addr_is(paddr, `PCRC_CTRL_OFS);

   // hardware clearing beats a software write in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_sel_ff <= pcrc_div_t'(`PCRC_CTRL_RST >> `PCRC_CTRL_DIV_LSB);
         compat_ff  <= 1'b0;
      end else if (rst_fall || wake) begin
         div_sel_ff <= PCRC_DIV_FULL;
      end else if (wr_en) begin
         div_sel_ff <= pcrc_div_t'(pwdata[`PCRC_CTRL_DIV_MSB:`PCRC_CTRL_DIV_LSB]);
         compat_ff  <= pwdata[`PCRC_CTRL_COMPAT];
      end
   end

   pcrc_rate_div u_div (
      .pclk        (pclk),
      .presetn     (presetn),
      .tick_in     (mult_tick),
      .div_sel     (div_sel_ff),
      .compat_div2 (compat_ff),
      .sync_load   (rst_fall),
      .sync_phase  (phase_one_ff),
      .tick_out    (core_tick)
   );

   // two non-overlapping phases approximated as complements
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_one_ff   <= 1'b0;
         phase_three_ff <= 1'b1;
      end else if (core_tick) begin
         phase_one_ff   <= ~phase_one_ff;
         phase_three_ff <= phase_one_ff;
      end
   end

   // oscillator feedback and multiplier power follow the mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crystal_drive_output_ff <= 1'b0;
         pwr_ff  <= 1'b0;
      end else begin
         crystal_drive_output_ff <= (mode != PCRC_MODE_STATIC) && !crystal_input;
         pwr_ff  <= (mode == PCRC_MODE_X5);
      end
   end

   // bus drain: pending access gets up to ten core cycles
   assign drain_done = !bus_access_pending
                       || (core_tick && drain_cnt_ff == (`PCRC_DRAIN_CYC - 4'h1));

   always_comb begin
      nxt_bus_st = bus_st_ff;
      case (bus_st_ff)
         PCRC_BUS_RUN: begin
            if (!rst_n_ff)
               nxt_bus_st = output_float_request_n ? PCRC_BUS_DRAIN : PCRC_BUS_FLOAT;
         end
         PCRC_BUS_DRAIN: begin
            if (!output_float_request_n || drain_done)
               nxt_bus_st = PCRC_BUS_FLOAT;
            else if (rst_n_ff)
               nxt_bus_st = PCRC_BUS_RUN;
         end
         PCRC_BUS_FLOAT: begin
            if (rst_n_ff)
               nxt_bus_st = PCRC_BUS_RUN;
         end
         default: nxt_bus_st = PCRC_BUS_FLOAT;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_st_ff    <= PCRC_BUS_FLOAT;
         drain_cnt_ff <= 4'h0;
         end_ff       <= 1'b1;
         in_rst_ff    <= 1'b1;
      end else begin
         bus_st_ff <= nxt_bus_st;
         end_ff    <= (nxt_bus_st != PCRC_BUS_RUN);
         in_rst_ff <= !rst_n_ff;
         if (bus_st_ff != PCRC_BUS_DRAIN)
            drain_cnt_ff <= 4'h0;
         else if (core_tick)
            drain_cnt_ff <= drain_cnt_ff + 4'h1;
      end
   end

   // float request clears enables with no clock edge needed
   assign oe_clr_n = presetn & output_float_request_n;

   always_ff @(posedge pclk or negedge oe_clr_n) begin
      if (!oe_clr_n) begin
         clk_oe_ff <= 1'b0;
         bus_oe_ff <= 1'b0;
      end else begin
         clk_oe_ff <= 1'b1;
         bus_oe_ff <= (nxt_bus_st == PCRC_BUS_RUN);
      end
   end

   // status word
   always_comb begin
      stat = 32'h0000_0000;
      stat[`PCRC_STAT_MODE_MSB:`PCRC_STAT_MODE_LSB] = mode;
      stat[`PCRC_STAT_LOCKED]  = lock_done_ff;
      stat[`PCRC_STAT_X5_USE]  = x5_use_ff;
      stat[`PCRC_STAT_REF_OK]  = ref_info.present;
      stat[`PCRC_STAT_ACQ]     = ref_info.acquired;
      stat[`PCRC_STAT_STOPPED] = (div_sel_ff == PCRC_DIV_STOP);
      stat[`PCRC_STAT_IN_RST]  = in_rst_ff;
      stat[`PCRC_STAT_BUS_MSB:`PCRC_STAT_BUS_LSB] = bus_st_ff;
      stat[`PCRC_STAT_CNT_MSB:`PCRC_STAT_CNT_LSB] = lock_cnt_ff;
   end

   // apb: read data and error captured in the setup cycle, no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff  <= 32'h0000_0000;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         pready_ff <= 1'b1;
         if (psel && !penable) begin
            if (addr_is(paddr, `PCRC_CTRL_OFS)) begin
               prdata_ff  <= {29'h0000_0000, compat_ff, div_sel_ff};
               pslverr_ff <= 1'b0;
            end else if (addr_is(paddr, `PCRC_STAT_OFS)) begin
               prdata_ff  <= pwrite ? 32'h0000_0000 : stat;
               pslverr_ff <= pwrite;
            end else begin
               prdata_ff  <= 32'h0000_0000;
               pslverr_ff <= 1'b1;
            end
         end
      end
   end

   assign prdata               = prdata_ff;
   assign pready               = pready_ff;
   assign pslverr              = pslverr_ff;
   assign crystal_drive_output = crystal_drive_output_ff;
   assign multiplier_power_on  = pwr_ff;
   assign phase_clock_one      = phase_one_ff;
   assign phase_clock_three    = phase_three_ff;
   assign clock_out_oe         = clk_oe_ff;
   assign bus_pins_oe          = bus_oe_ff;
   assign bus_access_end       = end_ff;
   assign core_in_reset        = in_rst_ff;
endmodule : pcrc_top

/* File: pcrc_params.svh */
// constants for the clock generator and reset control block
// assumes inclusion by the package only; the modules see its macros from there
`ifndef PCRC_PARAMS_SVH
`define PCRC_PARAMS_SVH

// register byte offsets
`define PCRC_CTRL_OFS      12'h000
`define PCRC_STAT_OFS      12'h004

// control register fields and reset value
`define PCRC_CTRL_DIV_LSB  0
`define PCRC_CTRL_DIV_MSB  1
`define PCRC_CTRL_COMPAT   2
`define PCRC_CTRL_RST      3'h0

// status register fields
`define PCRC_STAT_MODE_LSB 0
`define PCRC_STAT_MODE_MSB 1
`define PCRC_STAT_LOCKED   2
`define PCRC_STAT_X5_USE   3
`define PCRC_STAT_REF_OK   4
`define PCRC_STAT_ACQ      5
`define PCRC_STAT_STOPPED  6
`define PCRC_STAT_IN_RST   7
`define PCRC_STAT_BUS_LSB  8
`define PCRC_STAT_BUS_MSB  9
`define PCRC_STAT_CNT_LSB  16
`define PCRC_STAT_CNT_MSB  23

// multiplier and lock counter
`define PCRC_MULT          4'h5
`define PCRC_LOCK_LAST     8'hff

// divider and bus drain
`define PCRC_SIXTEENTH_LAST 4'hf
`define PCRC_DRAIN_CYC     4'ha

// reference watchdog, pclk cycles without a reference rise
`define PCRC_REF_LOST_CYC  255

`endif

/* File: pcrc_pkg.sv */
// types shared by the clock generator and reset control block
// assumes pcrc_params.svh is on the include path
package pcrc_pkg;
`include "pcrc_params.svh"

   // code is {mode select low, mode select high}
   typedef enum logic [1:0] {
      PCRC_MODE_STATIC = 2'b00,
      PCRC_MODE_HALF   = 2'b01,
      PCRC_MODE_UNITY  = 2'b10,
      PCRC_MODE_X5     = 2'b11
   } pcrc_mode_t;

   typedef enum logic [1:0] {
      PCRC_DIV_FULL      = 2'b00,
      PCRC_DIV_SIXTEENTH = 2'b01,
      PCRC_DIV_STOP      = 2'b10,
      PCRC_DIV_SPARE     = 2'b11
   } pcrc_div_t;

   typedef enum logic [1:0] {
      PCRC_BUS_RUN   = 2'b00,
      PCRC_BUS_DRAIN = 2'b01,
      PCRC_BUS_FLOAT = 2'b10
   } pcrc_bus_t;

   typedef struct packed {
      logic        rise;
      logic        present;
      logic        acquired;
      logic [11:0] period;
   } pcrc_ref_t;

endpackage : pcrc_pkg

/* File: pcrc_ref_front.sv */
// reference front end: merges the two reference inputs, finds rising
// edges, measures the period and watches for a missing reference
// assumes reference inputs are synchronous to pclk
`timescale 1ns/1ps
module pcrc_ref_front
   import pcrc_pkg::*;
#(
   parameter int LOST_CYC = `PCRC_REF_LOST_CYC
) (
   input  wire logic      pclk,
   input  wire logic      presetn,
   input  wire logic      crystal_input,
   input  wire logic      external_reference_input,
   output pcrc_ref_t      ref_info
);
   logic        ref_lvl_ff;
   logic        ref_prev_ff;
   logic [11:0] cnt_ff;
   logic [11:0] period_ff;
   logic [1:0]  edges_ff;
   logic        rise;

   // unused input is grounded, so the xor passes the active one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ref_lvl_ff  <= 1'b0;
         ref_prev_ff <= 1'b0;
      end else begin
         ref_lvl_ff  <= crystal_input ^ external_reference_input;
         ref_prev_ff <= ref_lvl_ff;
      end
   end

   assign rise = ref_lvl_ff & ~ref_prev_ff;

   // period tracking continues after acquisition
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_ff    <= 12'h000;
         period_ff <= 12'h000;
         edges_ff  <= 2'h0;
      end else if (rise) begin
         cnt_ff    <= 12'h000;
         period_ff <= cnt_ff + 12'h001;
         if (edges_ff != 2'h2)
            edges_ff <= edges_ff + 2'h1;
      end else begin
         if (cnt_ff != 12'hfff)
            cnt_ff <= cnt_ff + 12'h001;
         if (cnt_ff >= 12'(LOST_CYC))
            edges_ff <= 2'h0;
      end
   end

   assign ref_info.rise     = rise;
   assign ref_info.present  = (cnt_ff < 12'(LOST_CYC)) && (edges_ff != 2'h0);
   assign ref_info.acquired = (edges_ff == 2'h2);
   assign ref_info.period   = period_ff;
endmodule : pcrc_ref_front

/* File: pcrc_rate_div.sv */
// core clock divider: full, sixteenth or stopped, then an optional
// further halving; emits one pulse per output clock period
// assumes tick_in is a one-cycle pulse per multiplier output period
`timescale 1ns/1ps
module pcrc_rate_div
   import pcrc_pkg::*;
(
   input  wire logic      pclk,
   input  wire logic      presetn,
   input  wire logic      tick_in,
   input  pcrc_div_t      div_sel,
   input  wire logic      compat_div2,
   input  wire logic      sync_load,
   input  wire logic      sync_phase,
   output logic           tick_out
);
   logic [3:0] pre_ff;
   logic       half_ff;
   logic       pre_tick;

   always_comb begin
      case (div_sel)
         PCRC_DIV_SIXTEENTH: pre_tick = tick_in && (pre_ff == `PCRC_SIXTEENTH_LAST);
         PCRC_DIV_STOP:      pre_tick = 1'b0;
         default:            pre_tick = tick_in;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         pre_ff <= 4'h0;
      else if (sync_load)
         pre_ff <= 4'h0;
      else if (tick_in && div_sel != PCRC_DIV_STOP)
         pre_ff <= pre_ff + 4'h1;
   end

   // phase taken at the reset fall keeps the halved clock continuous
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         half_ff <= 1'b0;
      else if (sync_load)
         half_ff <= sync_phase;
      else if (pre_tick)
         half_ff <= ~half_ff;
   end

   assign tick_out = compat_div2 ? (pre_tick & half_ff) : pre_tick;
endmodule : pcrc_rate_div

/* File: pcrc_monitor.sv */
// checker for the clock generator and reset control block
// assumes binding into pcrc_top; all pins in the pclk domain
`timescale 1ns/1ps
module pcrc_monitor
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clock_mode_select_low,
   input wire logic clock_mode_select_high,
   input wire logic crystal_input,
   input wire logic device_reset_n,
   input wire logic output_float_request_n,
   input wire logic bus_access_pending,
   input wire logic crystal_drive_output,
   input wire logic multiplier_power_on,
   input wire logic phase_clock_one,
   input wire logic phase_clock_three,
   input wire logic clock_out_oe,
   input wire logic bus_pins_oe,
   input wire logic bus_access_end,
   input wire logic core_in_reset
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_mult_power_on: assert property (
      clock_mode_select_low && clock_mode_select_high |=> multiplier_power_on)
      else $error("x5 mode without multiplier power");
   a_static_all_off: assert property (
      !clock_mode_select_low && !clock_mode_select_high
      |=> !multiplier_power_on && !crystal_drive_output)
      else $error("static mode with feedback or power on");
   a_feedback_inverts: assert property (
      clock_mode_select_low || clock_mode_select_high
      |=> crystal_drive_output == !$past(crystal_input))
      else $error("crystal drive not inverse of input");
   a_phase_pair: assert property (
      $changed(phase_clock_one) |-> phase_clock_three == $past(phase_clock_one))
      else $error("phase three not lagging one");
   a_float_clears: assert property (
      !output_float_request_n [*2] |-> !clock_out_oe && !bus_pins_oe)
      else $error("outputs on under float request");
   a_oe_restores: assert property (
      output_float_request_n [*2] |-> clock_out_oe)
      else $error("clock output off without float request");
   a_core_reset: assert property (
      !device_reset_n [*2] |=> core_in_reset)
      else $error("core not in reset");
   a_bus_end_flag: assert property (
      !device_reset_n [*2] |=> bus_access_end)
      else $error("bus end flag missing in reset");
   a_idle_float: assert property (
      (!device_reset_n && !bus_access_pending) [*3] |=> !bus_pins_oe)
      else $error("bus pins driven, none pending");
   a_reset_float: assert property (
      (!device_reset_n && !output_float_request_n) [*2]
      |=> bus_access_end && !bus_pins_oe)
      else $error("reset with float request did not float");
endmodule : pcrc_monitor

bind pcrc_top pcrc_monitor u_monitor (
   .pclk(pclk), .presetn(presetn), .clock_mode_select_low(clock_mode_select_low),
   .clock_mode_select_high(clock_mode_select_high), .crystal_input(crystal_input),
   .device_reset_n(device_reset_n), .output_float_request_n(output_float_request_n),
   .bus_access_pending(bus_access_pending), .crystal_drive_output(crystal_drive_output),
   .multiplier_power_on(multiplier_power_on), .phase_clock_one(phase_clock_one),
   .phase_clock_three(phase_clock_three), .clock_out_oe(clock_out_oe),
   .bus_pins_oe(bus_pins_oe), .bus_access_end(bus_access_end),
   .core_in_reset(core_in_reset));

/* File: pcrc_ref_source.sv */
// reference clock source standing in for the crystal or external clock
// assumes the block samples its levels on pclk
`timescale 1ns/1ps
module pcrc_ref_source
#(
   parameter int HALF = 8
) (
   input  wire logic pclk,
   input  wire logic run,
   input  wire logic use_crystal,
   output logic      crystal_input,
   output logic      external_reference_input
);
   logic [7:0] cnt_ff = 8'h00;
   logic       lvl_ff = 1'b0;

   // runs from time zero, ahead of the first reset fall
   // stopped means stuck low, so a lost reference looks lost
   always_ff @(posedge pclk) begin
      if (!run) begin
         cnt_ff <= 8'h00;
         lvl_ff <= 1'b0;
      end else if (cnt_ff == 8'(HALF - 1)) begin
         cnt_ff <= 8'h00;
         lvl_ff <= ~lvl_ff;
      end else begin
         cnt_ff <= cnt_ff + 8'h01;
      end
   end

   // unused input held at ground
   assign crystal_input            = use_crystal & lvl_ff;
   assign external_reference_input = ~use_crystal & lvl_ff;
endmodule : pcrc_ref_source

/* File: pcrc_top_bench.sv */
// self-checking bench for the clock generator and reset control block
// assumes a 16-cycle reference period, so x5 gives 5 toggles per period
`timescale 1ns/1ps
module pcrc_top_bench
   import pcrc_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready, pslverr, xtal, extref, xdrive, mpwr, ph1, ph3;
   logic        mode_lo = 1'b1;
   logic        mode_hi = 1'b1;
   logic        device_reset_n = 1'b0;
   logic [3:0]  external_interrupt_n = 4'hf;
   logic        output_float_request_n = 1'b1;
   logic        bus_access_pending = 1'b0;
   logic        clock_out_oe, bus_pins_oe, bus_access_end, core_in_reset;
   logic        run = 1'b1;
   logic        use_crystal = 1'b0;
   logic        ph1_q = 1'b0;
   logic [31:0] rd;
   logic        err;
   int          tog = 0;
   int          miscompares = 0;
   int          check_count = 0;

   always #25 pclk = ~pclk;

   pcrc_ref_source #(.HALF(8)) u_ref (.pclk(pclk), .run(run), .use_crystal(use_crystal),
      .crystal_input(xtal), .external_reference_input(extref));

   pcrc_top #(.NUM_INT(4), .LOST_CYC(40)) dut (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .crystal_input(xtal),
      .external_reference_input(extref), .clock_mode_select_low(mode_lo),
      .clock_mode_select_high(mode_hi), .device_reset_n(device_reset_n),
      .external_interrupt_n(external_interrupt_n),
      .output_float_request_n(output_float_request_n),
      .bus_access_pending(bus_access_pending), .crystal_drive_output(xdrive),
      .multiplier_power_on(mpwr), .phase_clock_one(ph1), .phase_clock_three(ph3),
      .clock_out_oe(clock_out_oe), .bus_pins_oe(bus_pins_oe),
      .bus_access_end(bus_access_end), .core_in_reset(core_in_reset));

   // phase toggles give the core rate
   always @(posedge pclk) begin
      ph1_q <= ph1;
      if (ph1 !== ph1_q) tog <= tog + 1;
   end

   task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk

   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d = 32'h0000_0000);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // tolerance covers window phase against the reference
   task rate(input int cyc, input int exp, input string what);
      int t0;
      t0 = tog;
      repeat (cyc) @(posedge pclk);
      chk(32'((tog - t0 >= exp - 3) && (tog - t0 <= exp + 3)), 32'h0000_0001, what);
   endtask : rate

   task dev_reset(input int cyc);
      @(posedge pclk);
      device_reset_n <= 1'b0;
      repeat (cyc) @(posedge pclk);
      device_reset_n <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask : dev_reset

   task test_regs;
      apb(1'b0, 12'h000);
      chk(rd, 32'h0000_0000, "ctrl reset value");
      apb(1'b0, 12'h004);
      chk({rd[7], rd[1:0]}, 3'h7, "mode and in reset");
      apb(1'b0, 12'h008);
      chk({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
      apb(1'b1, 12'h004, 32'hffff_ffff);
      chk(err, 1'h1, "status write refused");
      apb(1'b1, 12'h000, 32'h0000_0005);
      apb(1'b0, 12'h000);
      chk(rd, 32'h0000_0005, "ctrl readback");
      apb(1'b1, 12'h000, 32'h0000_0000);
      $display("test regs done");
   endtask : test_regs

   task test_lock;
      logic [7:0] c1;
      int         n;
      repeat (4200) @(posedge pclk);
      apb(1'b0, 12'h004);
      chk(rd[23:16], 8'h00, "count frozen in reset");
      @(posedge pclk);
      device_reset_n <= 1'b1;
      rate(512, 16, "half rate locking");
      apb(1'b0, 12'h004);
      chk(rd[2], 1'h0, "not yet locked");
      run <= 1'b0;
      repeat (100) @(posedge pclk);
      apb(1'b0, 12'h004);
      c1 = rd[23:16];
      repeat (200) @(posedge pclk);
      apb(1'b0, 12'h004);
      chk({rd[23:16], rd[4]}, {c1, 1'b0}, "count held, no reference");
      run <= 1'b1;
      n = 0;
      do begin
         apb(1'b0, 12'h004);
         n++;
      end while (rd[2] !== 1'b1 && n < 2000);
      chk(rd[2], 1'h1, "lock done");
      repeat (64) @(posedge pclk);
      rate(512, 160, "x5 after lock");
      dev_reset(8);
      rate(512, 160, "no slow start");
      $display("test lock done");
   endtask : test_lock

   task test_modes;
      int exp [4] = '{32, 16, 32, 160};
      for (int i = 0; i < 4; i++) begin
         @(posedge pclk);
         device_reset_n <= 1'b0;
         mode_lo <= i[1];
         mode_hi <= i[0];
         use_crystal <= (i == 2);
         repeat (8) @(posedge pclk);
         device_reset_n <= 1'b1;
         repeat (64) @(posedge pclk);
         rate(512, exp[i], "mode rate");
      end
      $display("test modes done");
   endtask : test_modes

   task test_div;
      apb(1'b1, 12'h000, 32'h0000_0001);
      rate(512, 10, "sixteenth rate");
      apb(1'b1, 12'h000, 32'h0000_0007);
      rate(512, 80, "halved rate");
      apb(1'b1, 12'h000, 32'h0000_0002);
      apb(1'b0, 12'h004);
      chk(rd[6], 1'h1, "clock stopped");
      rate(256, 0, "no toggles stopped");
      external_interrupt_n <= 4'hb;
      repeat (4) @(posedge pclk);
      external_interrupt_n <= 4'hf;
      apb(1'b0, 12'h000);
      chk(rd[1:0], 2'h0, "interrupt wake");
      rate(512, 160, "rate after wake");
      apb(1'b1, 12'h000, 32'h0000_0001);
      dev_reset(4);
      apb(1'b0, 12'h000);
      chk(rd[1:0], 2'h0, "reset clears divider");
      $display("test div done");
   endtask : test_div

   task test_drain;
      @(posedge pclk);
      bus_access_pending <= 1'b1;
      device_reset_n <= 1'b0;
      repeat (3) @(posedge pclk);
      #1;
      chk({bus_access_end, bus_pins_oe}, 2'h2, "drain starts");
      apb(1'b0, 12'h004);
      chk(rd[9:8], 2'h1, "draining");
      repeat (40) @(posedge pclk);
      apb(1'b0, 12'h004);
      chk(rd[9:8], 2'h2, "float after ten cycles");
      bus_access_pending <= 1'b0;
      device_reset_n <= 1'b1;
      repeat (4) @(posedge pclk);
      #1;
      chk(bus_pins_oe, 1'h1, "bus driven again");
      $display("test drain done");
   endtask : test_drain

   task test_float;
      @(posedge pclk);
      output_float_request_n <= 1'b0;
      #1;
      chk({clock_out_oe, bus_pins_oe}, 2'h0, "float at once");
      @(posedge pclk);
      device_reset_n <= 1'b0;
      @(posedge pclk);
      apb(1'b0, 12'h004);
      chk(rd[9:8], 2'h2, "reset and float");
      @(posedge pclk);
      output_float_request_n <= 1'b1;
      repeat (40) @(posedge pclk);
      device_reset_n <= 1'b1;
      repeat (4) @(posedge pclk);
      #1;
      chk({clock_out_oe, bus_pins_oe}, 2'h3, "outputs back");
      $display("test float done");
   endtask : test_float

   task tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      test_regs;
      test_lock;
      test_modes;
      test_div;
      test_drain;
      test_float;
      tally_and_finish;
   end

   // the tests take about 14000 cycles
   initial begin
      repeat (40000) @(posedge pclk);
      miscompares++;
      tally_and_finish;
   end
endmodule : pcrc_top_bench
